// *** lhpm_pkg.sv ***
// Package for the left headphone output mixer register bank.
// Assumes a byte-wide register port decoded by the surrounding control bus logic.
package lhpm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] LHPM_OFS_LINE2_L   = 8'h2d;
  localparam logic [7:0] LHPM_OFS_LEFT_INPUT_GAIN_AMP     = 8'h2e;
  localparam logic [7:0] LHPM_OFS_DAC_L     = 8'h2f;
  localparam logic [7:0] LHPM_OFS_LINE2_R   = 8'h30;
  localparam logic [7:0] LHPM_OFS_RIGHT_INPUT_GAIN_AMP     = 8'h31;
  localparam logic [7:0] LHPM_OFS_DAC_R     = 8'h32;
  localparam logic [7:0] LHPM_OFS_LEVEL     = 8'h33;
  localparam int         LHPM_NUM_SRC       = 6;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         LHPM_ROUTE_BIT     = 7;
  localparam int         LHPM_LVL_MSB       = 7;
  localparam int         LHPM_LVL_LSB       = 4;
  localparam int         LHPM_UNMUTE_BIT    = 3;
  localparam int         LHPM_HIZ_BIT       = 2;
  localparam int         LHPM_PEND_BIT      = 1;
  localparam int         LHPM_PWR_BIT       = 0;
  localparam logic [7:0] LHPM_SRC_RST       = 8'h00;
  localparam logic [7:0] LHPM_LEVEL_RST     = 8'h06;
  localparam logic [6:0] LHPM_MUTE_CODE_MIN = 7'h76;
  localparam logic [3:0] LHPM_LVL_MAX       = 4'h9;
  // ----------------------------------------
  // Gain settle time
  // ----------------------------------------
  localparam int         LHPM_SETTLE_NS     = 1000;
  localparam int         LHPM_CLK_NS        = 10;
  localparam int         LHPM_SETTLE_CYC    = (LHPM_SETTLE_NS + LHPM_CLK_NS - 1) / LHPM_CLK_NS;
  localparam logic [7:0] LHPM_SETTLE_LOAD   = 8'(LHPM_SETTLE_CYC);
endpackage : lhpm_pkg

// *** lhpm_regs.sv ***
// Left headphone output mixer register bank and analog control outputs.
// Assumes a synchronous byte register port on core_clk from the control bus.
// Summary of operation
// R1 - Each left source is routed into the left headphone mix only while its bit 7 is 1.
// R2 - Each right source is added into the left headphone mix only while its bit 7 is 1.
// R3 - Each source register holds a 7-bit attenuation code in bits 6..0, reset 0.
// R4 - Attenuation codes step about 0.5 dB down to 117, and codes 118 to 127 mute.
// R5 - Level bits 7..4 set output gain 0 to 9 dB, reset 0.
// R6 - Software never writes level codes 10 to 15, which are reserved.
// R7 - Level bit 3 at 0 mutes the output and at 1 unmutes it, reset 0.
// R8 - Level bit 2 picks weak common-mode drive (0) or high impedance (1) when off, reset 1.
// R9 - Level bit 1 reads 1 while a programmed gain is pending, 0 once applied, reset 1.
// R10 - Level bit 0 at 1 fully powers the output driver, reset 0.
// R11 - Pending status rises on any accepted gain write and clears once the gain has settled.
`timescale 1ns/1ps
module lhpm_regs (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  output logic      [5:0] src_route_en,
  output logic      [41:0] src_atten,
  output logic      [5:0] src_muted,
  output logic      [3:0] out_level_gain,
  output logic            out_unmute,
  output logic            out_hiz_when_off,
  output logic            out_power_up,
  output logic            gain_pending
);
  import lhpm_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] src_r   [LHPM_NUM_SRC];
  logic [7:0] src_nxt [LHPM_NUM_SRC];
  logic [3:0] lvl_r, lvl_nxt;
  logic       unmute_r, unmute_nxt;
  logic       hiz_r, hiz_nxt;
  logic       pwr_r, pwr_nxt;
  logic       pend_r, pend_nxt;
  logic [7:0] settle_r, settle_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       src_sel;
  logic [2:0] src_idx;
  logic       lvl_sel;
  logic       gain_wr;

  // One-hot settle tracker states
  typedef enum logic [1:0] {
    LHPM_ST_IDLE   = 2'b01,
    LHPM_ST_SETTLE = 2'b10
  } lhpm_settle_e;
  lhpm_settle_e state_r, state_nxt;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    src_sel = (reg_addr >= LHPM_OFS_LINE2_L) && (reg_addr <= LHPM_OFS_DAC_R);
    src_idx = 3'(reg_addr - LHPM_OFS_LINE2_L);
    lvl_sel = (reg_addr == LHPM_OFS_LEVEL);
  end
  assign reg_hit = src_sel || lvl_sel;
  assign gain_wr = reg_wr_en && reg_hit;

  // ----------------------------------------
  // Source registers
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < LHPM_NUM_SRC; i++) begin
      src_nxt[i] = src_r[i];
    end
    if (reg_wr_en && src_sel) begin
      src_nxt[src_idx] = reg_wdata;                                 // R1 R2 R3
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LHPM_NUM_SRC; i++) begin
        src_r[i] <= LHPM_SRC_RST;                                   // R1 R2 R3
      end
    end else begin
      for (int i = 0; i < LHPM_NUM_SRC; i++) begin
        src_r[i] <= src_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Level register
  // ----------------------------------------
  always_comb begin
    lvl_nxt    = lvl_r;
    unmute_nxt = unmute_r;
    hiz_nxt    = hiz_r;
    pwr_nxt    = pwr_r;
    // Bit 1 is not stored here; it mirrors the settle tracker below
    if (reg_wr_en && lvl_sel) begin
      // Reserved level codes are not filtered; software keeps clear of them
      lvl_nxt    = reg_wdata[LHPM_LVL_MSB:LHPM_LVL_LSB];           // R5 R6
      unmute_nxt = reg_wdata[LHPM_UNMUTE_BIT];                      // R7
      hiz_nxt    = reg_wdata[LHPM_HIZ_BIT];                         // R8
      pwr_nxt    = reg_wdata[LHPM_PWR_BIT];                         // R10
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_r    <= LHPM_LEVEL_RST[LHPM_LVL_MSB:LHPM_LVL_LSB];        // R5
      unmute_r <= LHPM_LEVEL_RST[LHPM_UNMUTE_BIT];                  // R7
      hiz_r    <= LHPM_LEVEL_RST[LHPM_HIZ_BIT];                     // R8
      pwr_r    <= LHPM_LEVEL_RST[LHPM_PWR_BIT];                     // R10
    end else begin
      lvl_r    <= lvl_nxt;
      unmute_r <= unmute_nxt;
      hiz_r    <= hiz_nxt;
      pwr_r    <= pwr_nxt;
    end
  end

  // ----------------------------------------
  // Gain settle tracker
  // ----------------------------------------
  // The analog ramp is not visible to this logic, so a fixed wait stands in for it
  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    pend_nxt   = pend_r;
    case (state_r)
      LHPM_ST_IDLE: begin
        if (gain_wr) begin
          state_nxt  = LHPM_ST_SETTLE;
          settle_nxt = LHPM_SETTLE_LOAD;                            // R11
          pend_nxt   = 1'b1;                                        // R9 R11
        end
      end
      LHPM_ST_SETTLE: begin
        // A new write restarts the wait, so the set wins over a clear
        if (gain_wr) begin
          settle_nxt = LHPM_SETTLE_LOAD;                            // R11
          pend_nxt   = 1'b1;                                        // R9 R11
        end else if (settle_r != 8'h00) begin
          settle_nxt = settle_r - 8'h01;
        end else begin
          state_nxt  = LHPM_ST_IDLE;
          pend_nxt   = 1'b0;                                        // R9 R11
        end
      end
      default: begin
        // An illegal code falls back to a full wait rather than a false clear
        state_nxt  = LHPM_ST_SETTLE;
        settle_nxt = LHPM_SETTLE_LOAD;
        pend_nxt   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= LHPM_ST_SETTLE;
      settle_r <= LHPM_SETTLE_LOAD;                                 // R11
      pend_r   <= LHPM_LEVEL_RST[LHPM_PEND_BIT];                    // R9
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
      pend_r   <= pend_nxt;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_en) begin
      // Unmapped offsets read as zero so a stray read shows no stale byte
      rdata_nxt = 8'h00;
      if (src_sel) begin
        rdata_nxt = src_r[src_idx];
      end else if (lvl_sel) begin
        rdata_nxt = {lvl_r, unmute_r, hiz_r, pend_r, pwr_r};        // R9
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Source slices
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < LHPM_NUM_SRC; g++) begin : g_src
      lhpm_src_if sif ();
      assign sif.value = src_r[g];
      lhpm_src_slice u_slice (
        .s (sif.slice)
      );
      assign src_route_en[g]      = sif.route_en;                  // R1 R2
      assign src_atten[g*7 +: 7]  = sif.atten;                     // R3
      assign src_muted[g]         = sif.muted;                     // R4
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign out_level_gain   = lvl_r;                                 // R5
  assign out_unmute       = unmute_r;                              // R7
  assign out_hiz_when_off = hiz_r;                                 // R8
  assign out_power_up     = pwr_r;                                 // R10
  assign gain_pending     = pend_r;                                // R9
  assign reg_rdata        = rdata_r;
endmodule : lhpm_regs

// *** lhpm_regs_chk.sv ***
// Port checker for the left headphone mixer register bank.
// Assumes it is bound to lhpm_regs and sees only its ports.
`timescale 1ns/1ps
module lhpm_regs_chk (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_hit,
  input wire logic [5:0]  src_route_en,
  input wire logic [41:0] src_atten,
  input wire logic [5:0]  src_muted,
  input wire logic [3:0]  out_level_gain,
  input wire logic        out_unmute,
  input wire logic        out_hiz_when_off,
  input wire logic        out_power_up,
  input wire logic        gain_pending
);
  import lhpm_pkg::*;
  // ----------------------------------------
  // Write and read relations
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic lw;
  assign lw = reg_wr_en && reg_addr == LHPM_OFS_LEVEL;
  lvl_gain_a: assert property (lw |=> out_level_gain == $past(reg_wdata[7:4]))
    else $error("level gain not taken");
  mute_ctl_a: assert property (lw |=> out_unmute == $past(reg_wdata[3]))
    else $error("mute not taken");
  hiz_ctl_a: assert property (lw |=> out_hiz_when_off == $past(reg_wdata[2]))
    else $error("drive style not taken");
  pwr_ctl_a: assert property (lw |=> out_power_up == $past(reg_wdata[0]))
    else $error("power not taken");
  pend_hold_a: assert property (reg_wr_en && reg_hit |=> gain_pending [*8])
    else $error("pending not held after write");
  left_src_a: assert property (reg_wr_en && reg_addr == LHPM_OFS_LINE2_L
    |=> {src_route_en[0], src_atten[6:0]} == $past(reg_wdata)) else $error("left source");
  right_src_a: assert property (reg_wr_en && reg_addr == LHPM_OFS_DAC_R
    |=> {src_route_en[5], src_atten[41:35]} == $past(reg_wdata)) else $error("right source");
  src_mute_a: assert property (src_muted[3] == (src_atten[27:21] >= LHPM_MUTE_CODE_MIN))
    else $error("mute decode wrong");
  rd_unmap_a: assert property (reg_rd_en && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : lhpm_regs_chk

bind lhpm_regs lhpm_regs_chk i_chk (.core_clk(core_clk), .arst_n(arst_n),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .src_route_en(src_route_en),
  .src_atten(src_atten), .src_muted(src_muted), .out_level_gain(out_level_gain),
  .out_unmute(out_unmute), .out_hiz_when_off(out_hiz_when_off),
  .out_power_up(out_power_up), .gain_pending(gain_pending));

// *** lhpm_src_if.sv ***
// Interface carrying one mixer source register between bank and its slice.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface lhpm_src_if;
  logic [7:0] value;
  logic       route_en;
  logic [6:0] atten;
  logic       muted;
  modport slice (input value, output route_en, output atten, output muted);
  modport bank  (output value, input route_en, input atten, input muted);
endinterface : lhpm_src_if

// *** lhpm_src_slice.sv ***
// One mixer source slice: splits a stored source register into controls.
// Assumes the stored value comes from a register in the bank.
`timescale 1ns/1ps
module lhpm_src_slice (
  lhpm_src_if.slice s
);
  import lhpm_pkg::*;
  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign s.route_en = s.value[LHPM_ROUTE_BIT];        // R1
  assign s.atten    = s.value[6:0];                   // R3
  // Upper codes silence the path whatever the route bit says
  assign s.muted    = (s.value[6:0] >= LHPM_MUTE_CODE_MIN); // R4
endmodule : lhpm_src_slice

// *** tb_left_hp_output_mixer_regs.sv ***
// Self-checking bench for the left headphone mixer register bank.
// Assumes lhpm_regs is the device under test and the bench drives its byte port.
`timescale 1ns/1ps
module tb_left_hp_output_mixer_regs;
  import lhpm_pkg::*;
  logic core_clk = 0, arst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic hit, unm, hiz, pwr, pend;
  logic [5:0] route, muted;
  logic [41:0] att;
  logic [3:0] gain;
  int bad_count = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  lhpm_regs i_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit),
    .src_route_en(route), .src_atten(att), .src_muted(muted), .out_level_gain(gain),
    .out_unmute(unm), .out_hiz_when_off(hiz), .out_power_up(pwr), .gain_pending(pend));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task check(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : check
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    check(rdata, e);
  endtask : rd_reg
  // Counts edges until pending reads low, sampling just after each edge;
  // a write leaves it high for the settle count plus one edge
  task wait_settle(input int exp);
    int n;
    n = 0;
    while (pend !== 1'b0 && n < 250) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(8'(n), 8'(exp));
  endtask : wait_settle
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    #1;
    check({gain, unm, hiz, pend, pwr}, LHPM_LEVEL_RST);
    check({2'h0, route}, 8'h00);
    check({route[0], att[6:0]}, LHPM_SRC_RST);
    check({2'h0, muted}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd_reg(LHPM_OFS_LINE2_L + 8'(i), i == 6 ? LHPM_LEVEL_RST : LHPM_SRC_RST);
    end
    // The seven reads above took two edges each out of the wait after reset
    wait_settle(LHPM_SETTLE_CYC + 1 - 14);
    rd_reg(LHPM_OFS_LEVEL, 8'h04);
  endtask : t_reset
  task t_sources;
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      // Codes 117 to 122: only the first stays audible
      d = 8'h80 | (8'h75 + 8'(i));
      wr_reg(LHPM_OFS_LINE2_L + 8'(i), d);
      check({7'h0, pend}, 8'h01);
      check({7'h0, route[i]}, 8'h01);
      check({1'b0, att[i*7+:7]}, d & 8'h7f);
      check({7'h0, muted[i]}, 8'(i > 0));
      rd_reg(LHPM_OFS_LINE2_L + 8'(i), d);
    end
    wr_reg(LHPM_OFS_RIGHT_INPUT_GAIN_AMP, 8'h7f);
    check({7'h0, route[4]}, 8'h00);
    check({7'h0, muted[4]}, 8'h01);
    wr_reg(LHPM_OFS_LEFT_INPUT_GAIN_AMP, 8'h00);
    check({2'h0, route[1], muted[1], att[13:10]}, 8'h00);
    wait_settle(LHPM_SETTLE_CYC + 1);
  endtask : t_sources
  task t_level;
    wr_reg(LHPM_OFS_LEVEL, 8'h99);
    check({gain, unm, hiz, pend, pwr}, 8'h9b);
    rd_reg(LHPM_OFS_LEVEL, 8'h9b);
    // The read above spent two edges of the wait
    wait_settle(LHPM_SETTLE_CYC - 1);
    rd_reg(LHPM_OFS_LEVEL, 8'h99);
    // Bit 1 is status only, so writing 1 there must not stick
    wr_reg(LHPM_OFS_LEVEL, 8'h0e);
    wait_settle(LHPM_SETTLE_CYC + 1);
    check({gain, unm, hiz, pend, pwr}, 8'h0c);
  endtask : t_level
  task t_unmapped;
    wr_reg(8'h34, 8'hff);
    rd_reg(8'h34, 8'h00);
    rd_reg(8'h2c, 8'h00);
    check({7'h0, hit}, 8'h00);
    rd_reg(LHPM_OFS_LEVEL, 8'h0c);
    check({7'h0, hit}, 8'h01);
  endtask : t_unmapped
  // The tests need about 450 cycles; ten times that is left as margin
  initial begin
    #50000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1;
    t_reset();
    t_sources();
    t_level();
    t_unmapped();
    stop_test();
  end
endmodule : tb_left_hp_output_mixer_regs
